// >>> pinmux_pkg.sv
package pinmux_pkg;

  // Clock rate and the high-drive time of the opcode-fetch strobe.
  localparam int CLK_MHZ = 125;
  localparam int QUARTER_NS = 8;
  localparam int QUARTER_RAW = (QUARTER_NS * CLK_MHZ) / 1000;
  localparam int QUARTER_CLKS = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;
  localparam int CNT_W = 4;

  // Codes equal {mode_select_b, mode_select_a} as sampled during reset.
  typedef enum logic [1:0] {
    MODE_BOOTSTRAP = 2'b00,
    MODE_TEST = 2'b01,
    MODE_SINGLE = 2'b10,
    MODE_EXPANDED = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    STB_IDLE = 2'b00,
    STB_LOW = 2'b01,
    STB_HIGH = 2'b10
  } strobe_state_t;

  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_DATA = 3'b001,
    KIND_DIR = 3'b010,
    KIND_FUNC = 3'b011,
    KIND_SYSTEM_OPTIONS_TWO = 3'b100,
    KIND_MODE = 3'b101
  } reg_kind_t;

  // Register byte addresses.
  localparam logic [31:0] ADDR_SYSTEM_OPTIONS_TWO = 32'h0000_0038;
  localparam logic [31:0] ADDR_DATA_BASE = 32'h0000_0040;
  localparam logic [31:0] ADDR_DIR_BASE = 32'h0000_0060;
  localparam logic [31:0] ADDR_FUNC_BASE = 32'h0000_0080;
  localparam logic [31:0] ADDR_MODE = 32'h0000_00A0;
  localparam logic [31:0] BANK_MASK = 32'hFFFF_FFE3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int DRIVE_HIGH_BIT = 7;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Port indices; port p owns flat bits [p*8 +: 8].
  localparam int NPORTS = 8;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;
  localparam int PORT_H = 7;

  localparam logic [7:0] ALL_LINES = 8'hFF;
  localparam logic [7:0] NO_LINES = 8'h00;
  localparam logic [7:0] PORT_D_LINES = 8'h3F;
  localparam logic [7:0] G_EXT_LINES = 8'h3F;
  localparam logic [7:0] G_RW_LINE = 8'h80;
  localparam logic [7:0] H_PWM_LINES = 8'h0F;
  localparam logic [7:0] H_CS_LINES = 8'hF0;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the output follows once stages two and three agree.
// No reset, so it keeps sampling while the device reset is held.
module pin_sync (
  input wire logic i_clk,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge i_clk) begin
    s1_r <= i_pin;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  always_ff @(posedge i_clk) begin
    if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  assign o_level = level_r;
endmodule

// >>> port_lane.sv
`timescale 1ns/1ps
// One port: chooses bus, peripheral or general-purpose drive per line and
// registers the pin drive; absent or input-only lines never drive.
module port_lane #(
  parameter logic [7:0] LINES = 8'hFF,
  parameter logic [7:0] DRIVABLE = 8'hFF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] i_gpio_out,
  input wire logic [7:0] i_gpio_dir,
  input wire logic [7:0] i_func_sel,
  input wire logic [7:0] i_func_out,
  input wire logic [7:0] i_func_oe,
  input wire logic [7:0] i_bus_sel,
  input wire logic [7:0] i_bus_out,
  input wire logic [7:0] i_bus_oe,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic [7:0] o_level
);
  logic [7:0] out_r;
  logic [7:0] oe_r;
  logic [7:0] out_nxt;
  logic [7:0] oe_nxt;
  logic [7:0] level_raw;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_line
      pin_sync u_sync (
        .i_clk(i_clk),
        .i_pin(i_pin[b]),
        .o_level(level_raw[b])
      );
    end
  endgenerate

  always_comb begin
    out_nxt = (i_bus_sel & i_bus_out) | (~i_bus_sel & i_func_sel & i_func_out)
      | (~i_bus_sel & ~i_func_sel & i_gpio_out);
    oe_nxt = (i_bus_sel & i_bus_oe) | (~i_bus_sel & i_func_sel & i_func_oe)
      | (~i_bus_sel & ~i_func_sel & i_gpio_dir);
    out_nxt = out_nxt & LINES & DRIVABLE;
    oe_nxt = oe_nxt & LINES & DRIVABLE;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_r <= 8'h00;
      oe_r <= 8'h00;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign o_pin_out = out_r;
  assign o_pin_oe = oe_r;
  assign o_level = level_raw & LINES;
endmodule

// >>> mode_select_pin_mux.sv
`timescale 1ns/1ps
module mode_select_pin_mux #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [31:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [31:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic I_MODE_SELECT_A,
  input wire logic I_MODE_SELECT_B,
  output logic O_OPCODE_FETCH_STROBE,
  output logic O_OPCODE_FETCH_STROBE_OE,
  input wire logic [63:0] I_PORT_IN,
  output logic [63:0] O_PORT_OUT,
  output logic [63:0] O_PORT_OE,
  input wire logic I_OPCODE_FETCH,
  input wire logic [15:0] I_BUS_ADDR,
  input wire logic [7:0] I_BUS_DATA_OUT,
  input wire logic I_BUS_DATA_OE,
  input wire logic I_BUS_READ,
  output logic [7:0] O_BUS_DATA_IN,
  output logic [1:0] O_MODE,
  input wire logic [63:0] I_FUNC_OUT,
  input wire logic [63:0] I_FUNC_OE,
  output logic [63:0] O_PIN_LEVEL
);

  function automatic logic is_exp(input pinmux_pkg::mode_t m);
    is_exp = (m == pinmux_pkg::MODE_EXPANDED) || (m == pinmux_pkg::MODE_TEST);
  endfunction

  function automatic logic [7:0] port_lines(input int p);
    if (p == pinmux_pkg::PORT_D) begin
      port_lines = pinmux_pkg::PORT_D_LINES;
    end else if (p == pinmux_pkg::PORT_G && REDUCED) begin
      port_lines = pinmux_pkg::G_RW_LINE;
    end else if (p == pinmux_pkg::PORT_H && REDUCED) begin
      port_lines = pinmux_pkg::H_PWM_LINES;
    end else begin
      port_lines = pinmux_pkg::ALL_LINES;
    end
  endfunction

  function automatic pinmux_pkg::reg_kind_t reg_kind(input logic [31:0] a);
    logic [31:0] bank;
    bank = a & pinmux_pkg::BANK_MASK;
    if (a == pinmux_pkg::ADDR_SYSTEM_OPTIONS_TWO) begin
      reg_kind = pinmux_pkg::KIND_SYSTEM_OPTIONS_TWO;
    end else if (a == pinmux_pkg::ADDR_MODE) begin
      reg_kind = pinmux_pkg::KIND_MODE;
    end else if (bank == pinmux_pkg::ADDR_DATA_BASE) begin
      reg_kind = pinmux_pkg::KIND_DATA;
    end else if (bank == pinmux_pkg::ADDR_DIR_BASE) begin
      reg_kind = pinmux_pkg::KIND_DIR;
    end else if (bank == pinmux_pkg::ADDR_FUNC_BASE) begin
      reg_kind = pinmux_pkg::KIND_FUNC;
    end else begin
      reg_kind = pinmux_pkg::KIND_NONE;
    end
  endfunction

  logic mode_a_lvl;
  logic mode_b_lvl;
  pinmux_pkg::mode_t mode_r;
  pinmux_pkg::strobe_state_t stb_state_r;
  logic [pinmux_pkg::CNT_W-1:0] stb_cnt_r;
  logic [7:0] system_options_two_r;
  logic [7:0] data_r [pinmux_pkg::NPORTS];
  logic [7:0] dir_r [pinmux_pkg::NPORTS];
  logic [7:0] func_r [pinmux_pkg::NPORTS];
  logic [7:0] func_sel [pinmux_pkg::NPORTS];
  logic [7:0] bus_sel [pinmux_pkg::NPORTS];
  logic [7:0] bus_out [pinmux_pkg::NPORTS];
  logic [7:0] bus_oe [pinmux_pkg::NPORTS];
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  pinmux_pkg::reg_kind_t wkind;
  pinmux_pkg::reg_kind_t rkind;
  logic [2:0] widx;
  logic [2:0] ridx;
  logic [7:0] rval;

  pin_sync u_sync_mode_a (.i_clk(I_CLK), .i_pin(I_MODE_SELECT_A), .o_level(mode_a_lvl));
  pin_sync u_sync_mode_b (.i_clk(I_CLK), .i_pin(I_MODE_SELECT_B), .o_level(mode_b_lvl));

  // Mode follows the pins only while reset is held, then stays frozen.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mode_r <= pinmux_pkg::mode_t'({mode_b_lvl, mode_a_lvl});
    end
  end
  assign O_MODE = mode_r;

  // Fetch strobe: low for the fetch cycle, optionally driven high afterwards.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      stb_state_r <= pinmux_pkg::STB_IDLE;
      stb_cnt_r <= '0;
    end else begin
      case (stb_state_r)
        pinmux_pkg::STB_IDLE: begin
          if (I_OPCODE_FETCH) begin
            stb_state_r <= pinmux_pkg::STB_LOW;
          end
        end
        pinmux_pkg::STB_LOW: begin
          if (!I_OPCODE_FETCH && system_options_two_r[pinmux_pkg::DRIVE_HIGH_BIT]) begin
            stb_state_r <= pinmux_pkg::STB_HIGH;
            stb_cnt_r <= pinmux_pkg::CNT_W'(pinmux_pkg::QUARTER_CLKS - 1);
          end else if (!I_OPCODE_FETCH) begin
            stb_state_r <= pinmux_pkg::STB_IDLE;
          end
        end
        pinmux_pkg::STB_HIGH: begin
          if (I_OPCODE_FETCH) begin
            stb_state_r <= pinmux_pkg::STB_LOW;
          end else if (stb_cnt_r == '0) begin
            stb_state_r <= pinmux_pkg::STB_IDLE;
          end else begin
            stb_cnt_r <= stb_cnt_r - 1'b1;
          end
        end
        default: begin
          stb_state_r <= pinmux_pkg::STB_IDLE;
        end
      endcase
    end
  end

  // Pin A only drives in the expanded modes; it never drives while reset is held.
  assign O_OPCODE_FETCH_STROBE_OE = is_exp(mode_r)
    && (stb_state_r != pinmux_pkg::STB_IDLE);
  assign O_OPCODE_FETCH_STROBE = (stb_state_r == pinmux_pkg::STB_HIGH);

  // Selection of bus and peripheral functions per port.
  always_comb begin
    for (int p = 0; p < pinmux_pkg::NPORTS; p++) begin
      bus_sel[p] = pinmux_pkg::NO_LINES;
      bus_out[p] = pinmux_pkg::NO_LINES;
      bus_oe[p] = pinmux_pkg::NO_LINES;
      func_sel[p] = pinmux_pkg::NO_LINES;
    end
    if (is_exp(mode_r)) begin
      bus_sel[pinmux_pkg::PORT_B] = pinmux_pkg::ALL_LINES;
      bus_out[pinmux_pkg::PORT_B] = I_BUS_ADDR[15:8];
      bus_oe[pinmux_pkg::PORT_B] = pinmux_pkg::ALL_LINES;
      bus_sel[pinmux_pkg::PORT_C] = pinmux_pkg::ALL_LINES;
      bus_out[pinmux_pkg::PORT_C] = I_BUS_DATA_OUT;
      bus_oe[pinmux_pkg::PORT_C] = {8{I_BUS_DATA_OE}};
      bus_sel[pinmux_pkg::PORT_F] = pinmux_pkg::ALL_LINES;
      bus_out[pinmux_pkg::PORT_F] = I_BUS_ADDR[7:0];
      bus_oe[pinmux_pkg::PORT_F] = pinmux_pkg::ALL_LINES;
      bus_sel[pinmux_pkg::PORT_G] = pinmux_pkg::G_RW_LINE;
      bus_out[pinmux_pkg::PORT_G] = {I_BUS_READ, 7'b000_0000};
      bus_oe[pinmux_pkg::PORT_G] = pinmux_pkg::G_RW_LINE;
      func_sel[pinmux_pkg::PORT_G] = func_r[pinmux_pkg::PORT_G] & pinmux_pkg::G_EXT_LINES;
      func_sel[pinmux_pkg::PORT_H] = func_r[pinmux_pkg::PORT_H];
    end else begin
      func_sel[pinmux_pkg::PORT_H] = func_r[pinmux_pkg::PORT_H] & pinmux_pkg::H_PWM_LINES;
    end
    func_sel[pinmux_pkg::PORT_A] = func_r[pinmux_pkg::PORT_A];
    func_sel[pinmux_pkg::PORT_D] = func_r[pinmux_pkg::PORT_D];
    func_sel[pinmux_pkg::PORT_E] = func_r[pinmux_pkg::PORT_E];
  end

  genvar gp;
  generate
    for (gp = 0; gp < pinmux_pkg::NPORTS; gp++) begin : g_port
      port_lane #(
        .LINES(port_lines(gp)),
        .DRIVABLE((gp == pinmux_pkg::PORT_E) ? pinmux_pkg::NO_LINES : pinmux_pkg::ALL_LINES)
      ) u_lane (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_pin(I_PORT_IN[gp*8 +: 8]),
        .i_gpio_out(data_r[gp]),
        .i_gpio_dir(dir_r[gp]),
        .i_func_sel(func_sel[gp]),
        .i_func_out(I_FUNC_OUT[gp*8 +: 8]),
        .i_func_oe(I_FUNC_OE[gp*8 +: 8]),
        .i_bus_sel(bus_sel[gp]),
        .i_bus_out(bus_out[gp]),
        .i_bus_oe(bus_oe[gp]),
        .o_pin_out(O_PORT_OUT[gp*8 +: 8]),
        .o_pin_oe(O_PORT_OE[gp*8 +: 8]),
        .o_level(O_PIN_LEVEL[gp*8 +: 8])
      );
    end
  endgenerate
  assign O_BUS_DATA_IN = O_PIN_LEVEL[pinmux_pkg::PORT_C*8 +: 8];

  // Register bus: write address and data are held until both have arrived.
  assign O_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign O_AXI_WREADY = !w_held_r && !bvalid_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wkind = reg_kind(awaddr_r);
  assign widx = awaddr_r[4:2];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= pinmux_pkg::REG_RESET;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= pinmux_pkg::RESP_OKAY;
    end else begin
      if (O_AXI_AWREADY && I_AXI_AWVALID) begin
        aw_held_r <= 1'b1;
        awaddr_r <= I_AXI_AWADDR;
      end
      if (O_AXI_WREADY && I_AXI_WVALID) begin
        w_held_r <= 1'b1;
        wdata_r <= I_AXI_WDATA[7:0];
        wlane_r <= I_AXI_WSTRB[0];
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wkind == pinmux_pkg::KIND_NONE) ? pinmux_pkg::RESP_SLVERR
          : pinmux_pkg::RESP_OKAY;
      end else if (bvalid_r && I_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign O_AXI_BVALID = bvalid_r;
  assign O_AXI_BRESP = bresp_r;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      system_options_two_r <= pinmux_pkg::REG_RESET;
      for (int p = 0; p < pinmux_pkg::NPORTS; p++) begin
        data_r[p] <= pinmux_pkg::REG_RESET;
        dir_r[p] <= pinmux_pkg::REG_RESET;
        func_r[p] <= pinmux_pkg::REG_RESET;
      end
    end else if (do_write && wlane_r) begin
      case (wkind)
        pinmux_pkg::KIND_SYSTEM_OPTIONS_TWO: system_options_two_r <= wdata_r;
        pinmux_pkg::KIND_DATA: data_r[widx] <= wdata_r & port_lines(int'(widx));
        pinmux_pkg::KIND_DIR: dir_r[widx] <= wdata_r & port_lines(int'(widx));
        pinmux_pkg::KIND_FUNC: func_r[widx] <= wdata_r & port_lines(int'(widx));
        default: begin
        end
      endcase
    end
  end

  // Read path: a data register returns the pin level on lines set as inputs.
  assign rkind = reg_kind(I_AXI_ARADDR);
  assign ridx = I_AXI_ARADDR[4:2];
  always_comb begin
    case (rkind)
      pinmux_pkg::KIND_SYSTEM_OPTIONS_TWO: rval = system_options_two_r;
      pinmux_pkg::KIND_DATA: rval = (data_r[ridx] & dir_r[ridx])
        | (O_PIN_LEVEL[ridx*8 +: 8] & ~dir_r[ridx]);
      pinmux_pkg::KIND_DIR: rval = dir_r[ridx];
      pinmux_pkg::KIND_FUNC: rval = func_r[ridx];
      pinmux_pkg::KIND_MODE: rval = {5'b0_0000, REDUCED, mode_r};
      default: rval = pinmux_pkg::REG_RESET;
    endcase
  end

  assign O_AXI_ARREADY = !rvalid_r;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= pinmux_pkg::RESP_OKAY;
    end else if (O_AXI_ARREADY && I_AXI_ARVALID) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rval};
      rresp_r <= (rkind == pinmux_pkg::KIND_NONE) ? pinmux_pkg::RESP_SLVERR
        : pinmux_pkg::RESP_OKAY;
    end else if (I_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end
  assign O_AXI_RVALID = rvalid_r;
  assign O_AXI_RDATA = rdata_r;
  assign O_AXI_RRESP = rresp_r;

  property p_mode_hold;
    @(posedge I_CLK) disable iff (I_RST) !$past(I_RST) |-> $stable(mode_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after reset");

  property p_mode_code;
    @(posedge I_CLK) disable iff (I_RST)
      $fell(I_RST) |-> mode_r == $past({mode_b_lvl, mode_a_lvl});
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("mode code mismatch");

  property p_pin_a_quiet;
    @(posedge I_CLK) disable iff (I_RST) !is_exp(mode_r) |-> !O_OPCODE_FETCH_STROBE_OE;
  endproperty
  a_pin_a_quiet: assert property (p_pin_a_quiet) else $error("pin A driven");

  property p_strobe_low;
    @(posedge I_CLK) disable iff (I_RST)
      is_exp(mode_r) && I_OPCODE_FETCH |=> O_OPCODE_FETCH_STROBE_OE && !O_OPCODE_FETCH_STROBE;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe not low on fetch");

  property p_drive_high;
    @(posedge I_CLK) disable iff (I_RST)
      is_exp(mode_r) && stb_state_r == pinmux_pkg::STB_LOW && !I_OPCODE_FETCH
      && system_options_two_r[pinmux_pkg::DRIVE_HIGH_BIT] |=> O_OPCODE_FETCH_STROBE_OE
      && O_OPCODE_FETCH_STROBE ##1 !O_OPCODE_FETCH_STROBE;
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("strobe high drive wrong");

  property p_no_high;
    @(posedge I_CLK) disable iff (I_RST)
      O_OPCODE_FETCH_STROBE |-> $past(system_options_two_r[pinmux_pkg::DRIVE_HIGH_BIT]);
  endproperty
  a_no_high: assert property (p_no_high) else $error("strobe high while disabled");

  property p_port_widths;
    @(posedge I_CLK) disable iff (I_RST)
      O_PORT_OE[pinmux_pkg::PORT_D*8+6 +: 2] == 2'b00
      && O_PORT_OE[pinmux_pkg::PORT_E*8 +: 8] == pinmux_pkg::NO_LINES;
  endproperty
  a_port_widths: assert property (p_port_widths) else $error("absent line driven");

  property p_reduced;
    @(posedge I_CLK) disable iff (I_RST)
      REDUCED |-> O_PORT_OE[pinmux_pkg::PORT_G*8 +: 7] == 7'h00
      && O_PORT_OE[pinmux_pkg::PORT_H*8+4 +: 4] == 4'h0;
  endproperty
  a_reduced: assert property (p_reduced) else $error("omitted line driven");

  property p_gpio_modes;
    @(posedge I_CLK) disable iff (I_RST)
      !is_exp(mode_r) |=> O_PORT_OE[pinmux_pkg::PORT_B*8 +: 8] == $past(dir_r[pinmux_pkg::PORT_B])
      && O_PORT_OE[pinmux_pkg::PORT_G*8 +: 6] == $past(dir_r[pinmux_pkg::PORT_G][5:0]);
  endproperty
  a_gpio_modes: assert property (p_gpio_modes) else $error("port not general-purpose");

  // The pin registers leave reset one edge after release, so that edge is skipped.
  property p_bus_map;
    @(posedge I_CLK) disable iff (I_RST)
      !$past(I_RST) && is_exp(mode_r)
      |=> O_PORT_OUT[pinmux_pkg::PORT_F*8 +: 8] == $past(I_BUS_ADDR[7:0])
      && O_PORT_OUT[pinmux_pkg::PORT_B*8 +: 8] == $past(I_BUS_ADDR[15:8])
      && O_PORT_OUT[pinmux_pkg::PORT_G*8+7] == $past(I_BUS_READ);
  endproperty
  a_bus_map: assert property (p_bus_map) else $error("bus mapping wrong");

  property p_timer_func;
    @(posedge I_CLK) disable iff (I_RST)
      func_r[pinmux_pkg::PORT_A] == pinmux_pkg::ALL_LINES
      |=> O_PORT_OE[pinmux_pkg::PORT_A*8 +: 8] == $past(I_FUNC_OE[pinmux_pkg::PORT_A*8 +: 8]);
  endproperty
  a_timer_func: assert property (p_timer_func) else $error("timer port not passed");

  c_expanded: cover property (@(posedge I_CLK) disable iff (I_RST) is_exp(mode_r));
  c_strobe_high: cover property (@(posedge I_CLK) disable iff (I_RST) O_OPCODE_FETCH_STROBE);
  c_write: cover property (@(posedge I_CLK) disable iff (I_RST) O_AXI_BVALID && I_AXI_BREADY);
  c_read: cover property (@(posedge I_CLK) disable iff (I_RST) O_AXI_RVALID && I_AXI_RREADY);

endmodule

// >>> ext_side.sv
`timescale 1ns/1ps
// Far side of the pins: mode straps, the pull-up on mode pin A and external drivers.
module ext_side (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_code,
  input wire logic i_strobe,
  input wire logic i_strobe_oe,
  input wire logic [63:0] i_port_out,
  input wire logic [63:0] i_port_oe,
  output logic o_mode_a,
  output logic o_mode_b,
  output logic [63:0] o_port_in
);
  logic [63:0] idle_r;

  // Undriven lines flip every cycle so a stale level can never pass for a driven one.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_r <= 64'hA5A5_A5A5_A5A5_A5A5;
    end else begin
      idle_r <= ~idle_r;
    end
  end

  assign o_mode_b = i_code[1];
  // Pin A is pulled up when strapped high, so only the low phase pulls it down.
  assign o_mode_a = i_code[0] && !(i_strobe_oe && !i_strobe);
  assign o_port_in = (i_port_oe & i_port_out) | (~i_port_oe & idle_r);
endmodule

// >>> test_mode_select_pin_mux.sv
`timescale 1ns/1ps
module test_mode_select_pin_mux;
  logic clk, rst, awv, wv, bry, arv, rry, fetch, dat_oe, brd, bus;
  logic [31:0] awa, wd, ara;
  logic [15:0] baddr;
  logic [7:0] bdat;
  logic [63:0] fout, foe;
  logic [1:0] code, c;
  wire awr, wr_rdy, bv, arr, rv, stb, stb_oe, ma, mb;
  wire [1:0] br, rr, mode;
  wire [31:0] rdat;
  wire [63:0] pin, pout, poe, plvl;
  wire [7:0] bin;
  int miscompares, checks_done, cycles;

  mode_select_pin_mux mode_select_pin_mux_i (
    .I_CLK(clk), .I_RST(rst), .I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv),
    .O_AXI_AWREADY(awr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wv),
    .O_AXI_WREADY(wr_rdy), .O_AXI_BRESP(br), .O_AXI_BVALID(bv), .I_AXI_BREADY(bry),
    .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdat),
    .O_AXI_RRESP(rr), .O_AXI_RVALID(rv), .I_AXI_RREADY(rry), .I_MODE_SELECT_A(ma),
    .I_MODE_SELECT_B(mb), .O_OPCODE_FETCH_STROBE(stb), .O_OPCODE_FETCH_STROBE_OE(stb_oe),
    .I_PORT_IN(pin), .O_PORT_OUT(pout), .O_PORT_OE(poe), .I_OPCODE_FETCH(fetch),
    .I_BUS_ADDR(baddr), .I_BUS_DATA_OUT(bdat), .I_BUS_DATA_OE(dat_oe), .I_BUS_READ(brd),
    .O_BUS_DATA_IN(bin), .O_MODE(mode), .I_FUNC_OUT(fout), .I_FUNC_OE(foe),
    .O_PIN_LEVEL(plvl)
  );

  ext_side ext_side_i (
    .i_clk(clk), .i_rst(rst), .i_code(code), .i_strobe(stb), .i_strobe_oe(stb_oe),
    .i_port_out(pout), .i_port_oe(poe), .o_mode_a(ma), .o_mode_b(mb), .o_port_in(pin)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    chk(br, pinmux_pkg::RESP_OKAY);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
    chk({rr, rdat}, {er, 24'h00_0000, d});
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    {rst, awv, wv, bry, arv, rry, fetch} = 7'h7F & 7'h40;
    {awa, wd, ara} = '0;
    {dat_oe, brd, baddr, bdat, code} = {2'h3, 16'hA55A, 8'h3C, 2'h2};
    fout = 64'hC3C3_C3C3_C3C3_C3C3;
    foe = '1;
    for (int m = 0; m < 4; m++) begin
      c = m[1:0];
      bus = c[0];
      @(posedge clk);
      code <= c;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk(mode, c);
      rd(pinmux_pkg::ADDR_MODE, {6'h00, c}, pinmux_pkg::RESP_OKAY);
      rd(pinmux_pkg::ADDR_SYSTEM_OPTIONS_TWO, 8'h00, pinmux_pkg::RESP_OKAY);
      rd(32'h0000_1000, 8'h00, pinmux_pkg::RESP_SLVERR);
      settle();
      chk({poe[55], poe[47:40], poe[23:8]}, bus ? 25'h1FF_FFFF : 25'h0);
      chk({pout[55], pout[47:40], pout[23:8]}, bus ? 25'h15A3_CA5 : 25'h0);
      if (bus) chk(bin, 8'h3C);
      @(posedge clk);
      {dat_oe, brd} <= 2'h0;
      settle();
      chk({poe[23:16], pout[55]}, 9'h000);
      @(posedge clk);
      {dat_oe, brd} <= 2'h3;
      wr(pinmux_pkg::ADDR_DIR_BASE, 8'hFF);
      wr(pinmux_pkg::ADDR_DATA_BASE, 8'h96);
      wr(pinmux_pkg::ADDR_DIR_BASE + 32'h0000_000C, 8'hFF);
      wr(pinmux_pkg::ADDR_DIR_BASE + 32'h0000_0010, 8'hFF);
      settle();
      chk({poe[7:0], pout[7:0]}, 16'hFF96);
      chk(poe[39:24], 16'h003F);
      chk(plvl[7:0], 8'h96);
      rd(pinmux_pkg::ADDR_DATA_BASE, 8'h96, pinmux_pkg::RESP_OKAY);
      wr(pinmux_pkg::ADDR_FUNC_BASE, 8'hFF);
      wr(pinmux_pkg::ADDR_FUNC_BASE + 32'h0000_0018, 8'h3F);
      wr(pinmux_pkg::ADDR_FUNC_BASE + 32'h0000_001C, 8'hFF);
      settle();
      chk(pout[7:0], fout[7:0]);
      chk({poe[63:56], poe[53:48]}, bus ? 14'h3FFF : 14'h03C0);
      for (int k = 1; k >= 0; k--) begin
        wr(pinmux_pkg::ADDR_SYSTEM_OPTIONS_TWO, k ? 8'h80 : 8'h00);
        @(posedge clk);
        fetch <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({stb_oe, ma}, {bus, 1'b0});
        @(posedge clk);
        fetch <= 1'b0;
        @(posedge clk);
        #1 chk({stb_oe, stb_oe & stb}, {2{bus & k[0]}});
        @(posedge clk);
        #1 chk(stb_oe, 1'b0);
      end
    end
    finish_test();
  end
endmodule
